/* io_expander_pkg.sv */
`default_nettype none
package io_expander_pkg;
   // serial frame: address byte (read flag in msb) then one data byte
   localparam int FRAME_BITS    = 16;
   localparam int BYTE_BITS     = 8;
   localparam int RD_FLAG_BIT   = 7;
   localparam int BIT_CNT_W     = 5;

   // register select codes
   localparam logic [6:0] REG_SWITCH    = 7'h00;
   localparam logic [6:0] REG_LED       = 7'h01;
   localparam logic [6:0] REG_LCD_CTRL  = 7'h02;
   localparam logic [6:0] REG_CURSOR    = 7'h03;
   localparam logic [6:0] REG_LCD_CHAR  = 7'h04;
   localparam logic [6:0] REG_GLYPH_SEL = 7'h05;
   localparam logic [6:0] REG_GLYPH_ROW = 7'h06;
   localparam logic [6:0] REG_DIR_BASE  = 7'h08;
   localparam logic [6:0] REG_DATA_BASE = 7'h10;

   // lcd control fields
   localparam int CTRL_BACKLIGHT_BIT = 0;
   localparam int CTRL_CLEAR_BIT     = 1;
   localparam int CTRL_BUSY_BIT      = 2;

   // cursor fields: column in [4:0], row in bit 5
   localparam int CUR_COL_W   = 5;
   localparam int CUR_ROW_BIT = 5;
   localparam logic [4:0] COLS = 5'h10;

   // display memory: 32 character cells, then 8 glyphs of 8 rows
   localparam int MEM_AW          = 7;
   localparam int MEM_DEPTH       = 96;
   localparam int CELLS           = 32;
   localparam int CELL_AW         = 5;
   localparam int GLYPH_PTR_W     = 6;
   localparam logic [6:0] GLYPH_BASE = 7'h20;
   localparam logic [7:0] BLANK_CHAR = 8'h20;

   // reset values and the default read value
   localparam logic [7:0] LED_RST  = 8'h00;
   localparam logic [7:0] DIR_RST  = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [7:0] IDLE_RD  = 8'h00;
endpackage
`default_nettype wire

/* lcd_mem.sv */
`default_nettype none
module lcd_mem #(
   parameter int AW    = 7,
   parameter int DW    = 8,
   parameter int DEPTH = 96
) (
   input  wire logic          i_clk,
   // write port
   input  wire logic          i_we,
   input  wire logic [AW-1:0] i_waddr,
   input  wire logic [DW-1:0] i_wdata,
   // read port
   input  wire logic [AW-1:0] i_raddr,
   output logic      [DW-1:0] o_rdata
);
   if (DEPTH > (1 << AW) || DEPTH < 1) begin : g_bad_depth
      $error("lcd_mem depth does not fit address width");
   end

   logic [DW-1:0] mem [DEPTH];

   always_ff @(posedge i_clk) begin
      if (i_we && int'(i_waddr) < DEPTH) begin
         mem[i_waddr] <= i_wdata;
      end
   end

   always_ff @(posedge i_clk) begin
      o_rdata <= (int'(i_raddr) < DEPTH) ? mem[i_raddr] : '0;
   end
endmodule
`default_nettype wire

/* board_io_expander_spi.sv */
// Notes on behaviour
// [RULE1] three host read/write byte direction registers, bank index 0 to 2
// [RULE2] direction bit set makes the pin an output, clear makes it input
// [RULE3] data read gives driven value for outputs, pin level for inputs
// [RULE4] data write drives output pins; bits of input pins have no effect
// [RULE5] host is serial master at 1 Mbps in standard clock-phase framing
// [RULE6] host asserts chip select to reach this controller
// [RULE7] every access is a serial transfer naming the register; one data byte
// [RULE8] led register sets the leds and reads back what they show
// [RULE9] switch register reads the present dip switch state
// [RULE10] backlight switched on and off apart from display contents
// [RULE11] glyph slot 0 to 7 loaded with eight rows, top row first
// [RULE12] clear erases all cells and puts the cursor at upper left
// [RULE13] host sequences lcd setup: bus, lines, font, off, clear, on, backlight
// [RULE14] cursor column 0 to 15, row 0 or 1; the column goes to 16 after a character at column 15
// [RULE15] character goes at cursor, cursor advances, no wrap at row end
// [RULE16] character code zero is stored as glyph zero, not a terminator
// [RULE17] eight leds, eight switches, twenty-four pins and the lcd
// [RULE18] frame: address byte with read flag, then one data byte, one select
`default_nettype none
module board_io_expander_spi #(
   parameter int NUM_BANKS = 3
) (
   // clock and reset
   input  wire logic                   i_clk,
   input  wire logic                   i_sys_rst,
   // serial link
   input  wire logic                   i_spi_sclk,
   input  wire logic                   i_spi_cs_n,
   input  wire logic                   i_spi_mosi,
   output logic                        o_spi_miso,
   output logic                        o_spi_miso_oe,
   // general purpose pins
   input  wire logic [NUM_BANKS*8-1:0] i_gpio_in,
   output logic      [NUM_BANKS*8-1:0] o_gpio_out,
   output logic      [NUM_BANKS*8-1:0] o_gpio_oe,
   // leds and switches
   output logic      [7:0]             o_led,
   input  wire logic [7:0]             i_dip_sw,
   // lcd
   output logic                        o_backlight,
   output logic                        o_lcd_busy,
   input  wire logic [6:0]             i_disp_addr,
   output logic      [7:0]             o_disp_data
);
   if (NUM_BANKS < 1 || NUM_BANKS > 8) begin : g_bad_banks
      $error("NUM_BANKS must be 1 to 8");
   end

   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_CLEAR = 2'b10} clr_state_e;

   logic                                     sclk_q_reg;
   logic [io_expander_pkg::BIT_CNT_W-1:0]    cnt_reg;
   logic [7:0]                               rx_reg;
   logic [7:0]                               addr_reg;
   logic [7:0]                               tx_reg;
   logic [NUM_BANKS*8-1:0]                   dir_reg;
   logic [NUM_BANKS*8-1:0]                   out_reg;
   logic [NUM_BANKS*8-1:0]                   pin_rd;
   logic [io_expander_pkg::CUR_COL_W-1:0]    col_reg;
   logic                                     row_reg;
   logic [io_expander_pkg::GLYPH_PTR_W-1:0]  gptr_reg;
   logic [io_expander_pkg::CELL_AW-1:0]      clr_idx_reg;
   clr_state_e                               clr_state_reg;
   logic                                     sclk_rise;
   logic                                     sclk_fall;
   logic                                     wr_en;
   logic [6:0]                               wr_sel;
   logic [7:0]                               wr_data;
   logic [7:0]                               rd_val;
   logic                                     mem_we;
   logic [6:0]                               mem_waddr;
   logic [7:0]                               mem_wdata;
   logic                                     char_wr;
   logic                                     glyph_wr;

   assign sclk_rise = i_spi_sclk && !sclk_q_reg && !i_spi_cs_n;
   assign sclk_fall = !i_spi_sclk && sclk_q_reg && !i_spi_cs_n;
   assign wr_sel    = addr_reg[6:0];
   assign wr_data   = {rx_reg[6:0], i_spi_mosi};
   assign wr_en     = sclk_rise && !addr_reg[io_expander_pkg::RD_FLAG_BIT]
                      && cnt_reg == 5'(io_expander_pkg::FRAME_BITS - 1); // RULE7 RULE18
   assign char_wr   = wr_en && wr_sel == io_expander_pkg::REG_LCD_CHAR && clr_state_reg == ST_IDLE;
   assign glyph_wr  = wr_en && wr_sel == io_expander_pkg::REG_GLYPH_ROW;

   // per-pin readback: driven value or sampled level
   for (genvar b = 0; b < NUM_BANKS * 8; b++) begin : g_pin
      assign pin_rd[b] = dir_reg[b] ? out_reg[b] : i_gpio_in[b]; // RULE3
   end

   always_comb begin
      logic [6:0] sel;
      sel    = {rx_reg[5:0], i_spi_mosi};
      rd_val = io_expander_pkg::IDLE_RD;
      if (sel >= io_expander_pkg::REG_DIR_BASE && sel < io_expander_pkg::REG_DIR_BASE + 7'(NUM_BANKS)) begin
         rd_val = dir_reg[8*int'(sel - io_expander_pkg::REG_DIR_BASE) +: 8]; // RULE1
      end else if (sel >= io_expander_pkg::REG_DATA_BASE
                   && sel < io_expander_pkg::REG_DATA_BASE + 7'(NUM_BANKS)) begin
         rd_val = pin_rd[8*int'(sel - io_expander_pkg::REG_DATA_BASE) +: 8]; // RULE3
      end else begin
         case (sel)
            io_expander_pkg::REG_SWITCH:    rd_val = i_dip_sw; // RULE9
            io_expander_pkg::REG_LED:       rd_val = o_led; // RULE8
            io_expander_pkg::REG_LCD_CTRL: begin
               rd_val[io_expander_pkg::CTRL_BACKLIGHT_BIT] = o_backlight;
               rd_val[io_expander_pkg::CTRL_BUSY_BIT]      = o_lcd_busy;
            end
            io_expander_pkg::REG_CURSOR: begin
               rd_val[io_expander_pkg::CUR_COL_W-1:0]  = col_reg;
               rd_val[io_expander_pkg::CUR_ROW_BIT]    = row_reg;
            end
            io_expander_pkg::REG_GLYPH_SEL: rd_val = {2'b00, gptr_reg};
            default:                        rd_val = io_expander_pkg::IDLE_RD;
         endcase
      end
   end

   // serial shifter, mode 0: sample on rising; first miso bit set on the eighth rising edge, later bits on falling
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sclk_q_reg    <= 1'b0;
         cnt_reg       <= '0;
         rx_reg        <= '0;
         addr_reg      <= '0;
         tx_reg        <= '0;
         o_spi_miso    <= 1'b0;
         o_spi_miso_oe <= 1'b0;
      end else begin
         sclk_q_reg    <= i_spi_sclk;
         o_spi_miso_oe <= !i_spi_cs_n;
         if (i_spi_cs_n) begin
            cnt_reg <= '0; // RULE18
         end else if (sclk_rise) begin
            rx_reg <= {rx_reg[6:0], i_spi_mosi};
            if (cnt_reg < 5'(io_expander_pkg::FRAME_BITS)) begin
               cnt_reg <= cnt_reg + 5'd1;
            end
            if (cnt_reg == 5'(io_expander_pkg::BYTE_BITS - 1)) begin
               addr_reg <= {rx_reg[6:0], i_spi_mosi};
               if (rx_reg[io_expander_pkg::RD_FLAG_BIT - 1]) begin
                  tx_reg     <= rd_val; // RULE7
                  o_spi_miso <= rd_val[7];
               end else begin
                  tx_reg     <= '0;
                  o_spi_miso <= 1'b0;
               end
            end
         end else if (sclk_fall && cnt_reg > 5'(io_expander_pkg::BYTE_BITS)
                      && cnt_reg < 5'(io_expander_pkg::FRAME_BITS)) begin
            o_spi_miso <= tx_reg[6];
            tx_reg     <= {tx_reg[6:0], 1'b0};
         end
      end
   end

   // general purpose pin registers
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         dir_reg <= {NUM_BANKS{io_expander_pkg::DIR_RST}};
         out_reg <= {NUM_BANKS{io_expander_pkg::DATA_RST}};
      end else if (wr_en) begin
         for (int b = 0; b < NUM_BANKS; b++) begin
            if (wr_sel == io_expander_pkg::REG_DIR_BASE + 7'(b)) begin
               dir_reg[8*b +: 8] <= wr_data; // RULE1
            end
            if (wr_sel == io_expander_pkg::REG_DATA_BASE + 7'(b)) begin
               out_reg[8*b +: 8] <= wr_data; // RULE4
            end
         end
      end
   end

   assign o_gpio_out = out_reg; // RULE4
   assign o_gpio_oe  = dir_reg; // RULE2

   // leds and backlight
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_led       <= io_expander_pkg::LED_RST;
         o_backlight <= 1'b0;
      end else if (wr_en) begin
         if (wr_sel == io_expander_pkg::REG_LED) begin
            o_led <= wr_data; // RULE8 RULE17
         end
         if (wr_sel == io_expander_pkg::REG_LCD_CTRL) begin
            o_backlight <= wr_data[io_expander_pkg::CTRL_BACKLIGHT_BIT]; // RULE10
         end
      end
   end

   // clear sequencer and cursor
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         clr_state_reg <= ST_IDLE;
         clr_idx_reg   <= '0;
         col_reg       <= '0;
         row_reg       <= 1'b0;
         o_lcd_busy    <= 1'b0;
      end else begin
         case (clr_state_reg)
            ST_IDLE: begin
               if (wr_en && wr_sel == io_expander_pkg::REG_LCD_CTRL
                   && wr_data[io_expander_pkg::CTRL_CLEAR_BIT]) begin
                  clr_state_reg <= ST_CLEAR;
                  clr_idx_reg   <= '0;
                  o_lcd_busy    <= 1'b1;
               end else if (wr_en && wr_sel == io_expander_pkg::REG_CURSOR) begin
                  col_reg <= {1'b0, wr_data[io_expander_pkg::CUR_COL_W-2:0]}; // RULE14
                  row_reg <= wr_data[io_expander_pkg::CUR_ROW_BIT]; // RULE14
               end else if (char_wr && col_reg < io_expander_pkg::COLS) begin
                  col_reg <= col_reg + 5'd1; // RULE15
               end
            end
            ST_CLEAR: begin
               clr_idx_reg <= clr_idx_reg + 5'd1;
               if (clr_idx_reg == 5'(io_expander_pkg::CELLS - 1)) begin
                  clr_state_reg <= ST_IDLE;
                  o_lcd_busy    <= 1'b0;
                  col_reg       <= '0; // RULE12
                  row_reg       <= 1'b0;
               end
            end
            default: clr_state_reg <= ST_IDLE;
         endcase
      end
   end

   // glyph row pointer, auto-advances after each row
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         gptr_reg <= '0;
      end else if (wr_en && wr_sel == io_expander_pkg::REG_GLYPH_SEL) begin
         gptr_reg <= {wr_data[2:0], 3'b000}; // RULE11
      end else if (glyph_wr) begin
         gptr_reg <= gptr_reg + 6'd1; // RULE11
      end
   end

   always_comb begin
      mem_we    = 1'b0;
      mem_waddr = '0;
      mem_wdata = '0;
      if (clr_state_reg == ST_CLEAR) begin
         mem_we    = 1'b1;
         mem_waddr = {2'b00, clr_idx_reg}; // RULE12
         mem_wdata = io_expander_pkg::BLANK_CHAR;
      end else if (char_wr && col_reg < io_expander_pkg::COLS) begin
         mem_we    = 1'b1; // RULE15
         mem_waddr = {2'b00, row_reg, col_reg[3:0]};
         mem_wdata = wr_data; // RULE16
      end else if (glyph_wr) begin
         mem_we    = 1'b1;
         mem_waddr = io_expander_pkg::GLYPH_BASE + {1'b0, gptr_reg}; // RULE11
         mem_wdata = wr_data;
      end
   end

   lcd_mem #(
      .AW    (io_expander_pkg::MEM_AW),
      .DW    (8),
      .DEPTH (io_expander_pkg::MEM_DEPTH)
   ) lcd_mem_inst (
      .i_clk   (i_clk),
      .i_we    (mem_we),
      .i_waddr (mem_waddr),
      .i_wdata (mem_wdata),
      .i_raddr (i_disp_addr),
      .o_rdata (o_disp_data)
   );

   // checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   property p_dir_wr;
      wr_en && wr_sel == io_expander_pkg::REG_DIR_BASE |=> o_gpio_oe[7:0] == $past(wr_data);
   endproperty
   a_dir_wr: assert property (p_dir_wr) else $error("direction write lost"); // RULE1

   property p_dir_pin;
      wr_en && wr_sel == io_expander_pkg::REG_DIR_BASE && wr_data[0] |=> o_gpio_oe[0] ##1 o_gpio_oe[0];
   endproperty
   a_dir_pin: assert property (p_dir_pin) else $error("pin not made output"); // RULE2

   property p_sw_read;
      sclk_rise && cnt_reg == 5'd7 && rx_reg[6] && {rx_reg[5:0], i_spi_mosi} == 7'h00
      |=> o_spi_miso == $past(i_dip_sw[7]);
   endproperty
   a_sw_read: assert property (p_sw_read) else $error("switch msb not on miso"); // RULE9

   property p_data_wr;
      wr_en && wr_sel == io_expander_pkg::REG_DATA_BASE |=> o_gpio_out[7:0] == $past(wr_data);
   endproperty
   a_data_wr: assert property (p_data_wr) else $error("data write lost"); // RULE4

   property p_led;
      wr_en && wr_sel == io_expander_pkg::REG_LED |=> o_led == $past(wr_data) ##1 o_led == $past(o_led);
   endproperty
   a_led: assert property (p_led) else $error("led value wrong"); // RULE8

   property p_backlight;
      wr_en && wr_sel == io_expander_pkg::REG_LCD_CTRL
      |=> o_backlight == $past(wr_data[io_expander_pkg::CTRL_BACKLIGHT_BIT]);
   endproperty
   a_backlight: assert property (p_backlight) else $error("backlight wrong"); // RULE10

   property p_clear;
      $rose(o_lcd_busy) |-> o_lcd_busy [*8] ##[24:26] (!o_lcd_busy && col_reg == '0 && !row_reg);
   endproperty
   a_clear: assert property (p_clear) else $error("clear timing or cursor wrong"); // RULE12

   property p_col_range;
      col_reg <= io_expander_pkg::COLS;
   endproperty
   a_col_range: assert property (p_col_range) else $error("cursor column out of range"); // RULE14

   property p_advance;
      char_wr && col_reg < io_expander_pkg::COLS && !o_lcd_busy |=> col_reg == $past(col_reg) + 5'd1;
   endproperty
   a_advance: assert property (p_advance) else $error("cursor did not advance"); // RULE15

   property p_glyph;
      glyph_wr |=> gptr_reg == $past(gptr_reg) + 6'd1;
   endproperty
   a_glyph: assert property (p_glyph) else $error("glyph row pointer stuck"); // RULE11

   property p_frame_len;
      cnt_reg <= 5'(io_expander_pkg::FRAME_BITS);
   endproperty
   a_frame_len: assert property (p_frame_len) else $error("frame counter overran"); // RULE18

   c_write: cover property (wr_en);
   c_read: cover property (sclk_rise && cnt_reg == 5'd7 && rx_reg[6]);
   c_clear: cover property ($fell(o_lcd_busy));
   c_glyph: cover property (glyph_wr);
endmodule
`default_nettype wire

/* spi_host_model.sv */
`default_nettype none
module spi_host_model (
   // clock
   input  wire logic i_clk,
   // serial link, host side
   input  wire logic i_spi_miso,
   input  wire logic i_spi_miso_oe,
   output logic      o_spi_sclk,
   output logic      o_spi_cs_n,
   output logic      o_spi_mosi
);
   timeunit 1ns;
   timeprecision 1ps;

   // half bit time in clocks: 25 gives 1 Mbps at 50 MHz
   int   half = 25;
   logic idle = 1'b1;

   initial begin
      o_spi_sclk = 1'b0;
      o_spi_cs_n = 1'b1;
      o_spi_mosi = 1'b0;
   end

   // data line carries no meaning outside frames
   always @(posedge i_clk) begin
      if (idle) begin
         o_spi_mosi <= ~o_spi_mosi;
      end
   end

   // mode 0, msb first; address byte then data byte in one select
   task automatic xfer(input logic [7:0] sel, input logic [7:0] wdat, input int nbits,
                       output logic [7:0] rdat);
      logic [15:0] sh;
      int          i;
      sh   = {sel, wdat};
      rdat = 8'h00;
      // claim the data line before the edge so the idle toggle never races the first bit
      idle = 1'b0;
      @(posedge i_clk);
      o_spi_cs_n <= 1'b0;
      o_spi_mosi <= sh[15];
      repeat (half) @(posedge i_clk);
      for (i = 0; i < nbits; i++) begin
         o_spi_sclk <= 1'b1;
         if (i >= 8) begin
            // an undriven line reads as the inverse of what the device last showed
            rdat = {rdat[6:0], i_spi_miso_oe ? i_spi_miso : ~i_spi_miso};
         end
         repeat (half) @(posedge i_clk);
         o_spi_sclk <= 1'b0;
         if (i < 15) begin
            o_spi_mosi <= sh[14-i];
         end
         repeat (half) @(posedge i_clk);
      end
      o_spi_cs_n <= 1'b1;
      idle       <= 1'b1;
      repeat (4) @(posedge i_clk);
   endtask
endmodule
`default_nettype wire

/* board_io_expander_spi_tb.sv */
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin miscompares++; \
   $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module board_io_expander_spi_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic        i_clk = 1'b0;
   logic        i_sys_rst = 1'b1;
   wire logic   sclk, cs_n, mosi;
   logic        miso, miso_oe, backlight, busy;
   logic [23:0] i_gpio_in = 24'h00_0000;
   logic [23:0] gpio_out, gpio_oe;
   logic [7:0]  led, disp_data, d;
   logic [7:0]  i_dip_sw = 8'h00;
   logic [6:0]  i_disp_addr = 7'h00;
   int          miscompares = 0;
   int          tests_run = 0;
   int          cycles = 0;

   board_io_expander_spi #(.NUM_BANKS(3)) board_io_expander_spi_inst (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_spi_sclk(sclk), .i_spi_cs_n(cs_n),
      .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(miso_oe), .i_gpio_in(i_gpio_in),
      .o_gpio_out(gpio_out), .o_gpio_oe(gpio_oe), .o_led(led), .i_dip_sw(i_dip_sw),
      .o_backlight(backlight), .o_lcd_busy(busy), .i_disp_addr(i_disp_addr), .o_disp_data(disp_data));

   spi_host_model spi_host_model_inst (
      .i_clk(i_clk), .i_spi_miso(miso), .i_spi_miso_oe(miso_oe), .o_spi_sclk(sclk),
      .o_spi_cs_n(cs_n), .o_spi_mosi(mosi));

   initial begin
      forever #10 i_clk = ~i_clk;
   end

   task automatic wr(input logic [6:0] sel, input logic [7:0] v);
      logic [7:0] x;
      spi_host_model_inst.xfer({1'b0, sel}, v, 16, x);
   endtask

   task automatic rd(input logic [6:0] sel, output logic [7:0] v);
      spi_host_model_inst.xfer({1'b1, sel}, 8'h00, 16, v);
   endtask

   task automatic dsp(input logic [6:0] a, output logic [7:0] v);
      @(posedge i_clk);
      i_disp_addr <= a;
      repeat (2) @(posedge i_clk);
      #1 v = disp_data;
   endtask

   task automatic t_reset;
      `CHK("led", 8'h00, led)
      `CHK("oe", 24'h00_0000, gpio_oe)
      `CHK("out", 24'h00_0000, gpio_out)
      `CHK("bl", 1'b0, backlight)
      `CHK("busy", 1'b0, busy)
      `CHK("miso_oe", 1'b0, miso_oe)
   endtask

   task automatic t_led_sw;
      spi_host_model_inst.half = 4;
      wr(io_expander_pkg::REG_LED, 8'ha5);
      spi_host_model_inst.half = 25;
      `CHK("led", 8'ha5, led)
      rd(io_expander_pkg::REG_LED, d);
      `CHK("led rd", 8'ha5, d)
      @(posedge i_clk);
      i_dip_sw <= 8'h5a;
      rd(io_expander_pkg::REG_SWITCH, d);
      `CHK("sw", 8'h5a, d)
   endtask

   task automatic t_gpio;
      logic [7:0] dir, pin;
      for (int b = 0; b < 3; b++) begin
         dir = 8'h5a + 8'(b);
         pin = 8'h3c ^ 8'(b);
         @(posedge i_clk);
         i_gpio_in[8*b +: 8] <= pin;
         wr(io_expander_pkg::REG_DIR_BASE + 7'(b), dir);
         rd(io_expander_pkg::REG_DIR_BASE + 7'(b), d);
         `CHK("dir", dir, d)
         `CHK("oe", dir, gpio_oe[8*b +: 8])
         wr(io_expander_pkg::REG_DATA_BASE + 7'(b), 8'h96);
         `CHK("out", 8'h96 & dir, gpio_out[8*b +: 8] & dir)
         rd(io_expander_pkg::REG_DATA_BASE + 7'(b), d);
         `CHK("data", (8'h96 & dir) | (pin & ~dir), d)
      end
   endtask

   task automatic t_refuse;
      wr(7'h7f, 8'hff);
      rd(7'h7f, d);
      `CHK("unmapped", 8'h00, d)
      spi_host_model_inst.xfer({1'b0, io_expander_pkg::REG_LED}, 8'h3c, 12, d);
      `CHK("abort", 8'ha5, led)
   endtask

   task automatic t_lcd;
      int n;
      wr(io_expander_pkg::REG_LCD_CTRL, 8'h01);
      `CHK("bl on", 1'b1, backlight)
      rd(io_expander_pkg::REG_LCD_CTRL, d);
      `CHK("ctrl rd", 8'h01, d)
      n = 0;
      fork
         wr(io_expander_pkg::REG_LCD_CTRL, 8'h03);
         repeat (1000) begin
            @(posedge i_clk);
            #1 n += int'(busy === 1'b1);
         end
      join
      `CHK("busy len", 32, n)
      `CHK("bl kept", 1'b1, backlight)
      dsp(7'h00, d);
      `CHK("cell0", 8'h20, d)
      dsp(7'h1f, d);
      `CHK("cell31", 8'h20, d)
      rd(io_expander_pkg::REG_CURSOR, d);
      `CHK("home", 8'h00, d)
      wr(io_expander_pkg::REG_LCD_CTRL, 8'h00);
      `CHK("bl off", 1'b0, backlight)
      wr(io_expander_pkg::REG_LCD_CTRL, 8'h01);
      wr(io_expander_pkg::REG_CURSOR, 8'h2e);
      rd(io_expander_pkg::REG_CURSOR, d);
      `CHK("cursor", 8'h2e, d)
      wr(io_expander_pkg::REG_LCD_CHAR, 8'h00);
      wr(io_expander_pkg::REG_LCD_CHAR, 8'h41);
      wr(io_expander_pkg::REG_LCD_CHAR, 8'h42);
      dsp(7'h1e, d);
      `CHK("nul cell", 8'h00, d)
      dsp(7'h1f, d);
      `CHK("last cell", 8'h41, d)
      rd(io_expander_pkg::REG_CURSOR, d);
      `CHK("no wrap", 8'h30, d)
   endtask

   task automatic t_glyph;
      wr(io_expander_pkg::REG_GLYPH_SEL, 8'h07);
      rd(io_expander_pkg::REG_GLYPH_SEL, d);
      `CHK("gptr", 8'h38, d)
      for (int r = 0; r < 8; r++) begin
         wr(io_expander_pkg::REG_GLYPH_ROW, 8'h10 + 8'(r));
      end
      for (int r = 0; r < 8; r++) begin
         dsp(7'h58 + 7'(r), d);
         `CHK("grow", 8'h10 + 8'(r), d)
      end
   endtask

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 80000) begin
         miscompares++;
         conclude();
      end
   end

   initial begin
      repeat (10) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_clk);
      #1 t_reset();
      t_led_sw();
      t_gpio();
      t_refuse();
      t_lcd();
      t_glyph();
      conclude();
   end
endmodule
`undef CHK
`default_nettype wire
